/* rtl/mcs_pkg.sv */
// Constants, timing figures and state types for the module control/status logic.
// Assumes a single 40 MHz system clock; all slow timing runs on a 1 us tick.
// Function
// R1: Laser off pin rising turns optical output off within 10 us.
// R2: Laser off pin falling restores output within 1 ms.
// R3: After power-on or fault reset, initialise within 300 ms and clear fault.
// R4: Hardware laser fault output asserts within 100 us of a fault.
// R5: Host holds laser off pin high 10 us to reset a latched fault.
// R6: Signal lost output asserts within 100 us of optical input loss.
// R7: Signal lost output clears within 100 us of a valid input.
// R8: Soft laser off bit 6 of byte 110 disables output within 100 ms.
// R9: Clearing soft laser off bit restores output within 100 ms.
// R10: Soft fault status bit 2 sets within 100 ms of a fault.
// R11: Soft signal lost bit 1 sets within 100 ms of input loss.
// R12: Soft signal lost bit clears within 100 ms of a valid input.
// R13: Monitor data ready bit 0 asserts within 1000 ms of power-on.
// R14: Serial bus accesses are accepted no later than 300 ms after power-on.
// R15: Internal write of 1-8 bytes finishes within 10 ms of stop.
// R16: Host clocks the two-wire bus at no more than 400 kHz.
// R17: Loss detector uses peak-to-peak input power, not average power.
// R18: Effective laser off is the OR of pin and soft bit.
// R19: Soft fault and lost bits mirror the hardware outputs periodically.
// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package mcs_pkg;
    // Clock and tick
    localparam int CLK_NS = 25;
    localparam int T_US_NS = 1000;
    localparam logic [5:0] US_DIV = 6'(T_US_NS / CLK_NS);
    // Times in microseconds
    localparam int T_INIT_US = 300000;
    localparam int T_SERIAL_US = 300000;
    localparam int T_DATA_US = 1000000;
    localparam int T_WRITE_US = 10000;
    localparam int T_MIRROR_US = 1000;
    localparam logic [3:0] T_RESET_US = 4'hA;
    localparam logic [3:0] LOS_STABLE_US = 4'hA;
    localparam logic [3:0] FAULT_STABLE_US = 4'h2;
    // Register map
    localparam logic [6:0] DEV_ADDR = 7'h51;
    localparam logic [7:0] REG_CTRL_STATUS = 8'h6E;
    localparam int PIN_STATE_BIT = 7;
    localparam int SOFT_OFF_BIT = 6;
    localparam int FAULT_BIT = 2;
    localparam int LOST_BIT = 1;
    localparam int READY_BIT = 0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_WADDR, S_WDATA, S_ACK, S_RDATA, S_RACK
    } mcs_bus_st_type;

    typedef struct packed {
        logic [3:0] cnt;
        logic out;
    } mcs_filt_type;

    typedef struct packed {
        logic [5:0] div;
        logic tick;
        logic [19:0] init_cnt;
        logic [19:0] data_cnt;
        logic [19:0] ser_cnt;
        logic [19:0] busy_cnt;
        logic [19:0] mir_cnt;
        logic [3:0] hold_cnt;
        logic pin_r;
        logic fault_lat;
        logic laser_on;
        logic rx_lost;
        logic fault_mir;
        logic los_mir;
        logic soft_off;
        logic data_ready;
        logic scl_r;
        logic sda_r;
        mcs_bus_st_type st;
        mcs_bus_st_type after;
        logic [3:0] bitc;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic ackd;
        logic wrote;
        logic sda_oe;
    } mcs_state_type;
endpackage : mcs_pkg

/* rtl/mcs_filter.sv */
// Stability filter: output follows the input once it has held for STABLE ticks.
// Assumes tick is a one-cycle 1 us enable from the parent's divider.
`timescale 1ns/100ps
module mcs_filter #(
    parameter logic [3:0] STABLE = 4'hA
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Sample enable and data
    input wire logic tick,
    input wire logic din,
    output logic dout
);
    mcs_pkg::mcs_filt_type s_reg;
    mcs_pkg::mcs_filt_type s_next;

    // Restart the count on any bounce so glitches never pass
    always_comb begin
        s_next = s_reg;
        if (din == s_reg.out) begin
            s_next.cnt = 4'h0;
        end else if (tick) begin
            if (s_reg.cnt >= STABLE - 4'h1) begin
                s_next.out = din;
                s_next.cnt = 4'h0;
            end else begin
                s_next.cnt = s_reg.cnt + 4'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dout = s_reg.out;
endmodule : mcs_filter

/* rtl/mcs_ctrl_status.sv */
// Laser control, fault latch, signal-lost flag and control/status byte on a two-wire slave.
// Assumes scl and sda_in are already synchronous to clk_sys; srst marks power-on.
`timescale 1ns/100ps
module mcs_ctrl_status #(
    parameter logic [19:0] INIT_US = 20'(mcs_pkg::T_INIT_US),
    parameter logic [19:0] SERIAL_US = 20'(mcs_pkg::T_SERIAL_US),
    parameter logic [19:0] DATA_US = 20'(mcs_pkg::T_DATA_US),
    parameter logic [19:0] WRITE_US = 20'(mcs_pkg::T_WRITE_US),
    parameter logic [19:0] MIRROR_US = 20'(mcs_pkg::T_MIRROR_US)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Host control pins
    input wire logic laser_off_pin,
    output logic laser_fault,
    output logic receive_signal_lost,
    // Analog front end
    input wire logic fault_sense,
    input wire logic p2p_signal_detect,
    output logic laser_on,
    // Two-wire management bus, open drain
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    mcs_pkg::mcs_state_type s_reg;
    mcs_pkg::mcs_state_type s_next;
    logic fault_f;
    logic los_f;
    logic start_c, stop_c, rise_c, fall_c;
    logic ser_ready;
    logic pin_fell;
    logic [7:0] status;
    logic [7:0] rd_byte;

    // ------------------------------------------------------------------------
    // Input filters
    // ------------------------------------------------------------------------
    // Detector output already reflects peak-to-peak power, never average
    mcs_filter #(.STABLE(mcs_pkg::LOS_STABLE_US)) u_los_filt ( // R17
        .clk_sys(clk_sys),
        .srst(srst),
        .tick(s_reg.tick),
        .din(~p2p_signal_detect),
        .dout(los_f)
    );

    mcs_filter #(.STABLE(mcs_pkg::FAULT_STABLE_US)) u_fault_filt (
        .clk_sys(clk_sys),
        .srst(srst),
        .tick(s_reg.tick),
        .din(fault_sense),
        .dout(fault_f)
    );

    // ------------------------------------------------------------------------
    // Bus events and status byte
    // ------------------------------------------------------------------------
    assign start_c = scl & s_reg.scl_r & s_reg.sda_r & ~sda_in;
    assign stop_c = scl & s_reg.scl_r & ~s_reg.sda_r & sda_in;
    assign rise_c = scl & ~s_reg.scl_r;
    assign fall_c = ~scl & s_reg.scl_r;
    // Busy write cycle or early power-up refuses the address
    assign ser_ready = (s_reg.ser_cnt == 20'h0) && (s_reg.busy_cnt == 20'h0); // R14 R15
    assign pin_fell = s_reg.pin_r & ~laser_off_pin;

    // Status byte, unused bits read as zero
    always_comb begin
        status = 8'h00;
        status[mcs_pkg::PIN_STATE_BIT] = laser_off_pin;
        status[mcs_pkg::SOFT_OFF_BIT] = s_reg.soft_off;
        status[mcs_pkg::FAULT_BIT] = s_reg.fault_mir; // R19
        status[mcs_pkg::LOST_BIT] = s_reg.los_mir; // R19
        status[mcs_pkg::READY_BIT] = s_reg.data_ready;
        rd_byte = (s_reg.ptr == mcs_pkg::REG_CTRL_STATUS) ? status : mcs_pkg::UNMAPPED_READ;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.tick = (s_reg.div == mcs_pkg::US_DIV - 6'h1);
        s_next.div = s_next.tick ? 6'h0 : s_reg.div + 6'h1;
        s_next.pin_r = laser_off_pin;
        s_next.scl_r = scl;
        s_next.sda_r = sda_in;

        // Microsecond timers count down to zero and stay there; hold_cnt counts up to T_RESET_US and stays there
        if (s_reg.tick) begin
            if (s_reg.init_cnt != 20'h0) s_next.init_cnt = s_reg.init_cnt - 20'h1;
            if (s_reg.data_cnt != 20'h0) s_next.data_cnt = s_reg.data_cnt - 20'h1;
            if (s_reg.ser_cnt != 20'h0) s_next.ser_cnt = s_reg.ser_cnt - 20'h1;
            if (s_reg.busy_cnt != 20'h0) s_next.busy_cnt = s_reg.busy_cnt - 20'h1; // R15
            if (laser_off_pin && s_reg.hold_cnt < mcs_pkg::T_RESET_US) begin
                s_next.hold_cnt = s_reg.hold_cnt + 4'h1;
            end
        end
        if (!laser_off_pin) s_next.hold_cnt = 4'h0;

        // Long pin pulse resets a latched fault; without a fault the laser returns at once
        if (pin_fell && s_reg.hold_cnt >= mcs_pkg::T_RESET_US && s_reg.fault_lat) begin // R5
            s_next.fault_lat = 1'b0; // R3
            s_next.init_cnt = INIT_US; // R3
        end
        // A fault in the clearing cycle wins
        if (fault_f) s_next.fault_lat = 1'b1; // R4

        // Either source turns the laser off on the next edge
        s_next.laser_on = !(laser_off_pin || s_reg.soft_off) // R1 R2 R8 R9 R18
            && !s_next.fault_lat && (s_next.init_cnt == 20'h0); // R3
        s_next.rx_lost = los_f; // R6 R7

        // Periodic copy into the status byte, well inside the soft limits
        if (s_reg.tick) begin
            if (s_reg.mir_cnt == 20'h0) begin
                s_next.mir_cnt = MIRROR_US - 20'h1;
                s_next.fault_mir = s_reg.fault_lat; // R10 R19
                s_next.los_mir = s_reg.rx_lost; // R11 R12 R19
            end else begin
                s_next.mir_cnt = s_reg.mir_cnt - 20'h1;
            end
        end
        if (s_reg.data_cnt == 20'h0) s_next.data_ready = 1'b1; // R13

        // Two-wire slave: sample on rising scl, drive on falling scl
        if (rise_c) begin
            if (s_reg.st inside {mcs_pkg::S_ADDR, mcs_pkg::S_WADDR, mcs_pkg::S_WDATA}) begin
                s_next.shreg = {s_reg.shreg[6:0], sda_in};
                s_next.bitc = s_reg.bitc + 4'h1;
            end
            if (s_reg.st == mcs_pkg::S_RACK) s_next.ackd = ~sda_in;
        end
        if (fall_c) begin
            unique case (s_reg.st)
                mcs_pkg::S_IDLE: begin
                end
                mcs_pkg::S_ADDR, mcs_pkg::S_WADDR, mcs_pkg::S_WDATA: begin
                    if (s_reg.bitc == 4'h8) begin
                        s_next.bitc = 4'h0;
                        s_next.st = mcs_pkg::S_ACK;
                        s_next.sda_oe = 1'b1;
                        if (s_reg.st == mcs_pkg::S_ADDR) begin
                            s_next.after = s_reg.shreg[0] ? mcs_pkg::S_RDATA : mcs_pkg::S_WADDR;
                            if (s_reg.shreg[7:1] != mcs_pkg::DEV_ADDR || !ser_ready) begin // R14
                                s_next.st = mcs_pkg::S_IDLE;
                                s_next.sda_oe = 1'b0;
                            end
                        end else if (s_reg.st == mcs_pkg::S_WADDR) begin
                            s_next.ptr = s_reg.shreg;
                            s_next.after = mcs_pkg::S_WDATA;
                        end else begin
                            if (s_reg.ptr == mcs_pkg::REG_CTRL_STATUS) begin
                                s_next.soft_off = s_reg.shreg[mcs_pkg::SOFT_OFF_BIT]; // R8 R9
                            end
                            s_next.ptr = s_reg.ptr + 8'h1;
                            s_next.wrote = 1'b1;
                            s_next.after = mcs_pkg::S_WDATA;
                        end
                    end
                end
                mcs_pkg::S_ACK: begin
                    s_next.st = s_reg.after;
                    s_next.sda_oe = 1'b0;
                    if (s_reg.after == mcs_pkg::S_RDATA) begin
                        s_next.shreg = rd_byte;
                        s_next.sda_oe = ~rd_byte[7];
                    end
                end
                mcs_pkg::S_RDATA: begin
                    if (s_reg.bitc == 4'h7) begin
                        s_next.st = mcs_pkg::S_RACK;
                        s_next.sda_oe = 1'b0;
                        s_next.ptr = s_reg.ptr + 8'h1;
                    end else begin
                        s_next.bitc = s_reg.bitc + 4'h1;
                        s_next.shreg = {s_reg.shreg[6:0], 1'b0};
                        s_next.sda_oe = ~s_reg.shreg[6];
                    end
                end
                mcs_pkg::S_RACK: begin
                    // Host nack ends the read; the master then stops
                    s_next.st = s_reg.ackd ? mcs_pkg::S_RDATA : mcs_pkg::S_IDLE;
                    s_next.bitc = 4'h0;
                    s_next.shreg = rd_byte;
                    s_next.sda_oe = s_reg.ackd & ~rd_byte[7];
                end
            endcase
        end
        if (start_c) begin
            s_next.st = mcs_pkg::S_ADDR;
            s_next.bitc = 4'h0;
            s_next.sda_oe = 1'b0;
        end
        if (stop_c) begin
            s_next.st = mcs_pkg::S_IDLE;
            s_next.sda_oe = 1'b0;
            s_next.wrote = 1'b0;
            if (s_reg.wrote) s_next.busy_cnt = WRITE_US; // R15
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.init_cnt <= INIT_US;
            s_reg.data_cnt <= DATA_US;
            s_reg.ser_cnt <= SERIAL_US;
            s_reg.scl_r <= 1'b1;
            s_reg.sda_r <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign laser_on = s_reg.laser_on;
    assign laser_fault = s_reg.fault_lat;
    assign receive_signal_lost = s_reg.rx_lost;
    assign sda_out = 1'b0;
    assign sda_oe = s_reg.sda_oe;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_pin_off;
        @(posedge clk_sys) disable iff (srst) laser_off_pin |=> !laser_on;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("laser on while pin high"); // R1

    property p_soft_off;
        @(posedge clk_sys) disable iff (srst) s_reg.soft_off |=> !laser_on;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("laser on while soft off"); // R18

    property p_pin_on;
        @(posedge clk_sys) disable iff (srst)
            (pin_fell && !s_reg.soft_off && !s_reg.fault_lat && !fault_f
            && s_reg.init_cnt == 20'h0)
            |=> laser_on;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("laser not restored"); // R2

    property p_fault_reset;
        @(posedge clk_sys) disable iff (srst)
            (s_reg.fault_lat && pin_fell && s_reg.hold_cnt >= mcs_pkg::T_RESET_US && !fault_f)
            |=> !laser_fault && s_reg.init_cnt == INIT_US;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault not reset"); // R3

    property p_fault_set;
        @(posedge clk_sys) disable iff (srst) fault_f |=> laser_fault && !laser_on;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not latched"); // R4

    property p_los;
        @(posedge clk_sys) disable iff (srst) $changed(los_f) |=> receive_signal_lost == $past(los_f);
    endproperty
    a_los: assert property (p_los) else $error("signal lost not following"); // R6

    property p_mirror;
        @(posedge clk_sys) disable iff (srst)
            (s_reg.tick && s_reg.mir_cnt == 20'h0) |=> s_reg.los_mir == $past(s_reg.rx_lost)
            && s_reg.fault_mir == $past(s_reg.fault_lat);
    endproperty
    a_mirror: assert property (p_mirror) else $error("status mirror stale"); // R19

    property p_mirror_bound;
        @(posedge clk_sys) disable iff (srst) s_reg.mir_cnt < MIRROR_US;
    endproperty
    a_mirror_bound: assert property (p_mirror_bound) else $error("mirror period too long"); // R10

    property p_ready;
        @(posedge clk_sys) disable iff (srst) s_reg.data_ready == ($past(s_reg.data_cnt) == 20'h0);
    endproperty
    a_ready: assert property (p_ready) else $error("data ready wrong"); // R13

    property p_no_early_ack;
        @(posedge clk_sys) disable iff (srst)
            (s_reg.st == mcs_pkg::S_ACK && s_reg.after != mcs_pkg::S_WDATA && $changed(s_reg.st))
            |-> $past(ser_ready);
    endproperty
    a_no_early_ack: assert property (p_no_early_ack) else $error("address acked while not ready"); // R14

    property p_write_busy;
        @(posedge clk_sys) disable iff (srst) (stop_c && s_reg.wrote) |=> s_reg.busy_cnt == WRITE_US;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("write cycle not started"); // R15
endmodule : mcs_ctrl_status

/* verification/mcs_host_model.sv */
// Host model: two-wire bus master that reaches the control/status byte.
// Assumes a pull-up on the data line; sda is the resolved wire level.
`timescale 1ns/100ps
module mcs_host_model (
    // Clock
    input wire logic clk_sys,
    // Two-wire bus
    output logic scl,
    output logic sda_oe_host,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Bit level
    // ------------------------------------------------------------
    // Quarter bit of 25 cycles, so the bus clock is exactly 400 kHz
    task automatic qtr();
        repeat (25) @(negedge clk_sys);
    endtask : qtr

    // Start, also used as repeated start from a low clock
    task automatic start_cond();
        sda_oe_host = 1'h0;
        qtr();
        scl = 1'h1;
        qtr();
        sda_oe_host = 1'h1;
        qtr();
        scl = 1'h0;
        qtr();
    endtask : start_cond

    // Stop: data rises while the clock is high
    task automatic stop_cond();
        sda_oe_host = 1'h1;
        qtr();
        scl = 1'h1;
        qtr();
        sda_oe_host = 1'h0;
        qtr();
    endtask : stop_cond

    // Data only changes while the clock is low
    task automatic put_bit(input logic b);
        sda_oe_host = ~b;
        qtr();
        scl = 1'h1;
        qtr();
        qtr();
        scl = 1'h0;
        qtr();
    endtask : put_bit

    // Released line, sampled mid way through the high phase
    task automatic get_bit(output logic b);
        sda_oe_host = 1'h0;
        qtr();
        scl = 1'h1;
        qtr();
        b = sda;
        qtr();
        scl = 1'h0;
        qtr();
    endtask : get_bit

    // ------------------------------------------------------------
    // Byte and register level
    // ------------------------------------------------------------
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(nack);
        ack = ~nack;
    endtask : put_byte

    task automatic get_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask : get_byte

    // Write one byte, then allow the internal write time
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        put_byte({mcs_pkg::DEV_ADDR, 1'h0}, a0);
        put_byte(a, a1);
        put_byte(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
        repeat (480) @(negedge clk_sys);
    endtask : reg_write

    // Set pointer, repeated start, read one byte and refuse more
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start_cond();
        put_byte({mcs_pkg::DEV_ADDR, 1'h0}, a0);
        put_byte(a, a1);
        start_cond();
        put_byte({mcs_pkg::DEV_ADDR, 1'h1}, a2);
        get_byte(d, 1'h1);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : reg_read

    // Bus idle at time zero
    initial begin
        scl = 1'h1;
        sda_oe_host = 1'h0;
    end
endmodule : mcs_host_model

/* verification/mcs_ctrl_status_tb.sv */
// Testbench for the control/status block: pins, fault, signal loss and the status byte.
// Assumes mcs_host_model drives the bus; timers are shortened to 5 to 30 microseconds.
`timescale 1ns/100ps
module mcs_ctrl_status_tb;
    logic clk_sys;
    logic srst;
    logic laser_off_pin;
    logic fault_sense;
    logic p2p_signal_detect;
    logic laser_fault;
    logic receive_signal_lost;
    logic laser_on;
    logic scl;
    logic sda_out;
    logic sda_oe;
    logic sda_oe_host;
    logic sda;
    logic [7:0] rd;
    logic ok;
    int miscompares;
    int check_count;

    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'h1) & ~sda_oe_host;

    mcs_ctrl_status #(
        .INIT_US(20'h00014), .SERIAL_US(20'h00014), .DATA_US(20'h0001E),
        .WRITE_US(20'h0000A), .MIRROR_US(20'h00005)
    ) DUT (
        .clk_sys(clk_sys), .srst(srst), .laser_off_pin(laser_off_pin),
        .laser_fault(laser_fault), .receive_signal_lost(receive_signal_lost),
        .fault_sense(fault_sense), .p2p_signal_detect(p2p_signal_detect),
        .laser_on(laser_on), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
    );

    mcs_host_model HOST (.clk_sys(clk_sys), .scl(scl), .sda_oe_host(sda_oe_host), .sda(sda));

    // 40 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask : check

    function automatic logic probe(input int s);
        case (s)
            0: return laser_on;
            1: return laser_fault;
            default: return receive_signal_lost;
        endcase
    endfunction : probe

    // Bounded wait for a level, then compare it
    task automatic wait_level(input int s, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (probe(s) !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        check(nm, {7'h00, v}, {7'h00, probe(s)});
    endtask : wait_level

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        HOST.reg_read(a, rd, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check(nm, exp, rd);
    endtask : rd_chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        HOST.reg_write(a, d, ok);
        check("write ack", 8'h01, {7'h00, ok});
    endtask : wr

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'h1;
        laser_off_pin = 1'h0;
        fault_sense = 1'h0;
        p2p_signal_detect = 1'h1;
        repeat (4) @(negedge clk_sys);
        srst = 1'h0;
        repeat (400) @(negedge clk_sys);
        check("laser_on mid init", 8'h00, {7'h00, laser_on});
        wait_level(0, 1'h1, 800, "laser_on after init");
        repeat (500) @(negedge clk_sys);
        rd_chk(8'h6E, 8'h01, "status idle");
        // Hardware pin forces the transmitter off within a cycle or two
        laser_off_pin = 1'h1;
        repeat (2) @(negedge clk_sys);
        check("laser_on pin off", 8'h00, {7'h00, laser_on});
        rd_chk(8'h6E, 8'h81, "status pin");
        laser_off_pin = 1'h0;
        repeat (2) @(negedge clk_sys);
        check("laser_on pin on", 8'h01, {7'h00, laser_on});
        // All ones: only the soft off bit may stick
        wr(8'h6E, 8'hFF);
        check("laser_on soft off", 8'h00, {7'h00, laser_on});
        rd_chk(8'h6E, 8'h41, "status soft off");
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00, "unmapped byte");
        // Foreign device address is ignored: no ack
        HOST.start_cond();
        HOST.put_byte({7'h50, 1'h0}, ok);
        HOST.stop_cond();
        check("foreign address nack", 8'h00, {7'h00, ok});
        wr(8'h6E, 8'h00);
        check("laser_on soft on", 8'h01, {7'h00, laser_on});
        // Signal loss and its mirror
        p2p_signal_detect = 1'h0;
        wait_level(2, 1'h1, 4000, "lost set");
        rd_chk(8'h6E, 8'h03, "status lost");
        p2p_signal_detect = 1'h1;
        wait_level(2, 1'h0, 4000, "lost clear");
        rd_chk(8'h6E, 8'h01, "status found");
        // Fault latch, a short pulse that must not clear it, then a real clear
        fault_sense = 1'h1;
        wait_level(1, 1'h1, 4000, "fault set");
        check("laser_on fault", 8'h00, {7'h00, laser_on});
        fault_sense = 1'h0;
        rd_chk(8'h6E, 8'h05, "status fault");
        laser_off_pin = 1'h1;
        repeat (200) @(negedge clk_sys);
        laser_off_pin = 1'h0;
        repeat (80) @(negedge clk_sys);
        check("fault after short pulse", 8'h01, {7'h00, laser_fault});
        laser_off_pin = 1'h1;
        repeat (480) @(negedge clk_sys);
        laser_off_pin = 1'h0;
        repeat (4) @(negedge clk_sys);
        check("fault cleared", 8'h00, {7'h00, laser_fault});
        check("laser_on reinit", 8'h00, {7'h00, laser_on});
        wait_level(0, 1'h1, 1000, "laser_on after clear");
        // Second power-on in mid run
        srst = 1'h1;
        repeat (4) @(negedge clk_sys);
        srst = 1'h0;
        repeat (2) @(negedge clk_sys);
        check("laser_on second reset", 8'h00, {7'h00, laser_on});
        check("fault second reset", 8'h00, {7'h00, laser_fault});
        finish_test();
    end

    // Watchdog, well beyond the expected run of about 42k cycles
    initial begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
endmodule : mcs_ctrl_status_tb
